// *** logic/vout_margin_pkg.sv ***
// Purpose: shared constants and types for the margin and slew command block
// Assumes: 25 MHz ref_clk; word commands arrive already decoded from the bus
// Notes: slew figures are held in 2^-8 mV/us (q8) or 2^-4 mV/us (q4) units
package vout_margin_pkg;
   // command codes of the three word registers
   localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
   localparam logic [7:0] CMD_MARGIN_LOW = 8'h26;
   localparam logic [7:0] CMD_SLEW_RATE = 8'h27;
   // slew register field layout
   localparam int SLEW_EXP_MSB = 15;
   localparam int SLEW_EXP_LSB = 11;
   localparam int SLEW_MAN_MSB = 10;
   localparam logic [4:0] SLEW_EXP_RESET = 5'h1C;
   // signed exponent window that the decoder can scale
   localparam int SLEW_EXP_LOW = -8;
   localparam int SLEW_EXP_HIGH = 4;
   // valid programming range, 0.067 to 15.933 mV/us, in q8 units
   localparam logic [23:0] SLEW_MIN_Q8 = 24'h000012;
   localparam logic [23:0] SLEW_MAX_Q8 = 24'h000FEE;
   // q8 to q4 rounding to the nearest supported hardware step
   localparam logic [23:0] SLEW_ROUND_Q8 = 24'h000008;
   // margin field of the operation command
   localparam logic [1:0] MARGIN_NONE = 2'h0;
   localparam logic [1:0] MARGIN_LOW = 2'h1;
   localparam logic [1:0] MARGIN_HIGH = 2'h2;
   // slew is applied once per microsecond
   localparam int CLK_PERIOD_NS = 40;
   localparam int SLEW_TICK_NS = 1000;
   localparam int SLEW_TICK_CYCLES = SLEW_TICK_NS / CLK_PERIOD_NS;
   // reference code steps per mV, q8; default assumes 2^-12 V per code
   localparam int CODES_PER_MV_Q8 = 1049;
   localparam int RAMP_FRAC_BITS = 12;
   typedef enum {ST_LOAD, ST_RUN} load_state_t;
endpackage : vout_margin_pkg

// *** logic/ramp_if.sv ***
// Purpose: carries target, rate and result between the register bank and ramp
// Assumes: one clock domain
// Notes: step_mode low makes the ramp follow the target at once
`timescale 1ns/10ps
interface ramp_if;
   logic [15:0] target;
   logic [7:0] rate_q4;
   logic step_mode;
   logic [15:0] reference;
   logic busy;
   modport bank (output target, output rate_q4, output step_mode, input reference, input busy);
   modport ramp (input target, input rate_q4, input step_mode, output reference, output busy);
endinterface : ramp_if

// *** logic/vout_ramp.sv ***
// Purpose: slews the reference code toward the target at the programmed rate
// Assumes: rate_q4 is in 1/16 mV/us, target in reference codes
// Notes: fractional accumulator keeps slow rates from stalling
`timescale 1ns/10ps
module vout_ramp #(
   parameter int TICK_CYCLES = vout_margin_pkg::SLEW_TICK_CYCLES,
   parameter int CODES_Q8 = vout_margin_pkg::CODES_PER_MV_Q8
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   ramp_if.ramp rp
);
   localparam int FB = vout_margin_pkg::RAMP_FRAC_BITS;
   logic [7:0] tick_count;
   logic tick;
   logic [27:0] acc;
   logic [27:0] goal;
   logic [27:0] step;

   assign goal = {rp.target, {FB{1'b0}}};
   assign step = 28'(rp.rate_q4) * 28'(CODES_Q8);
   assign tick = (tick_count == 8'(TICK_CYCLES - 1));

   // microsecond tick that paces each slew step
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         tick_count <= 8'h00;
      else if (tick)
         tick_count <= 8'h00;
      else
         tick_count <= tick_count + 8'h01;
   end

   // outside conversion the soft-start logic owns the ramp, so just follow
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         acc <= 28'h0000000;
      else if (!rp.step_mode)
         acc <= goal;
      else if (tick && acc < goal)
         acc <= (goal - acc > step) ? acc + step : goal;
      else if (tick && acc > goal)
         acc <= (acc - goal > step) ? acc - step : goal;
   end

   // integer part drives the reference; busy while any step is pending
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rp.reference <= 16'h0000;
         rp.busy <= 1'b0;
      end
      else
      begin
         rp.reference <= acc[27:FB];
         rp.busy <= (acc != goal);
      end
   end
endmodule : vout_ramp

// *** logic/vout_margin_slew_commands.sv ***
// Purpose: margin high/low and slew-rate word registers with target selection
// Assumes: word read/write transactions arrive decoded with their command code
// Notes: invalid writes are dropped and reported; targets are clamped to limits
//
// Functional notes
// - margin high, margin low, slew answer at 25h, 26h, 27h by word access
// - margin high or low selects that value plus trim as the output target
// - moves into or out of margin ramp at the held slew rate
// - margin registers hold 16-bit unsigned values, relative or absolute per mode
// - margin plus trim is checked against the present maximum limit
// - unsupported margin writes flag invalid data and alert the host
// - programmed slew governs changes during conversion, not turn-on or turn-off
// - slew word is five-bit signed exponent over eleven-bit signed mantissa
// - slew exponent resets to minus four, 0.0625 mV/us per mantissa step
// - valid slew codes read back unchanged; nearest hardware rate is applied
// - accepted slew range is 0.067 to 15.933 mV/us
// - out-of-range slew writes flag invalid data and alert the host
// - trim is a signed 16-bit offset added to the margin targets
// - targets beyond max or min clamp to that limit and, while converting, raise a warning
`timescale 1ns/10ps
module vout_margin_slew_commands #(
   parameter int TICK_CYCLES = vout_margin_pkg::SLEW_TICK_CYCLES,
   parameter int CODES_Q8 = vout_margin_pkg::CODES_PER_MV_Q8
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   output logic rsp_valid,
   output logic rsp_ack,
   output logic [15:0] rsp_rdata,
   input wire logic nvm_ready,
   input wire logic [15:0] nvm_margin_high,
   input wire logic [15:0] nvm_margin_low,
   input wire logic [10:0] nvm_slew_mantissa,
   input wire logic [1:0] margin_sel,
   input wire logic relative_mode,
   input wire logic [15:0] nominal_target,
   input wire logic [15:0] vout_trim,
   input wire logic [15:0] vout_max,
   input wire logic [15:0] vout_min,
   input wire logic conversion_on,
   input wire logic status_clear,
   output logic [15:0] reference_code,
   output logic ramp_busy,
   output logic loaded,
   output logic invalid_data_status,
   output logic max_min_warn_status,
   output logic host_alert
);
   vout_margin_pkg::load_state_t load_state;
   logic [15:0] margin_high_value;
   logic [15:0] margin_low_value;
   logic [4:0] slew_exponent;
   logic [10:0] slew_mantissa;
   logic [7:0] applied_rate_q4;
   logic wr_high;
   logic wr_low;
   logic wr_slew;
   logic known_code;
   logic high_ok;
   logic low_ok;
   logic slew_ok;
   logic [23:0] wr_rate_q8;
   logic [23:0] nvm_rate_q8;
   logic [18:0] raw_target;
   logic [15:0] next_target;
   logic clamped;
   logic clamped_d;
   logic invalid_event;
   logic warn_event;

   ramp_if rp ();

   // decode a linear slew word into q8 units; zero for unusable exponents
   function automatic logic [23:0] slew_q8(input logic [4:0] ex, input logic [10:0] man);
      logic signed [5:0] e;
      logic [3:0] sh;
      e = 6'(signed'(ex));
      sh = 4'(e + 6'sd8);
      slew_q8 = 24'h000000;
      if (!man[10] && e >= 6'(vout_margin_pkg::SLEW_EXP_LOW)
          && e <= 6'(vout_margin_pkg::SLEW_EXP_HIGH))
         slew_q8 = 24'({13'h0000, man} << sh);
   endfunction : slew_q8

   // margin plus trim, plus nominal when the output mode is relative
   function automatic logic [18:0] margin_total(input logic [15:0] margin);
      logic [18:0] base;
      base = relative_mode ? {3'h0, nominal_target} : 19'h00000;
      margin_total = {3'h0, margin} + {{3{vout_trim[15]}}, vout_trim} + base;
   endfunction : margin_total

   // a combined target must not go negative nor pass the present maximum
   function automatic logic target_ok(input logic [18:0] total);
      target_ok = !total[18] && (total <= {3'h0, vout_max});
   endfunction : target_ok

   // write strobes only once the backup copy is in
   assign wr_high = cmd_valid && cmd_write && (load_state == vout_margin_pkg::ST_RUN)
                    && (cmd_code == vout_margin_pkg::CMD_MARGIN_HIGH);
   assign wr_low = cmd_valid && cmd_write && (load_state == vout_margin_pkg::ST_RUN)
                   && (cmd_code == vout_margin_pkg::CMD_MARGIN_LOW);
   assign wr_slew = cmd_valid && cmd_write && (load_state == vout_margin_pkg::ST_RUN)
                    && (cmd_code == vout_margin_pkg::CMD_SLEW_RATE);
   assign known_code = (cmd_code == vout_margin_pkg::CMD_MARGIN_HIGH)
                       || (cmd_code == vout_margin_pkg::CMD_MARGIN_LOW)
                       || (cmd_code == vout_margin_pkg::CMD_SLEW_RATE);

   // validity of the word on the bus; a process, so mode, trim and limit changes re-evaluate
   always_comb
   begin
      high_ok = target_ok(margin_total(cmd_wdata));
      low_ok = target_ok(margin_total(cmd_wdata));
   end
   assign wr_rate_q8 = slew_q8(cmd_wdata[15:11], cmd_wdata[10:0]);
   assign slew_ok = (wr_rate_q8 >= vout_margin_pkg::SLEW_MIN_Q8)
                    && (wr_rate_q8 <= vout_margin_pkg::SLEW_MAX_Q8);
   assign nvm_rate_q8 = slew_q8(vout_margin_pkg::SLEW_EXP_RESET, nvm_slew_mantissa);

   // unsupported data on any of the three registers is one event
   assign invalid_event = (wr_high && !high_ok) || (wr_low && !low_ok)
                          || (wr_slew && !slew_ok);

   // hold off the host until the backup values are captured
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         load_state <= vout_margin_pkg::ST_LOAD;
      else
      begin
         case (load_state)
            vout_margin_pkg::ST_LOAD:
               if (nvm_ready)
                  load_state <= vout_margin_pkg::ST_RUN;
            vout_margin_pkg::ST_RUN:
               load_state <= vout_margin_pkg::ST_RUN;
            default:
               load_state <= vout_margin_pkg::ST_LOAD;
         endcase
      end
   end

   // margin registers: backup copy first, then only valid host words
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         margin_high_value <= 16'h0000;
         margin_low_value <= 16'h0000;
      end
      else if (load_state == vout_margin_pkg::ST_LOAD && nvm_ready)
      begin
         margin_high_value <= nvm_margin_high;
         margin_low_value <= nvm_margin_low;
      end
      else
      begin
         if (wr_high && high_ok)
            margin_high_value <= cmd_wdata;
         if (wr_low && low_ok)
            margin_low_value <= cmd_wdata;
      end
   end

   // slew register stored exactly as written; the exponent keeps its pattern at reset
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         slew_exponent <= vout_margin_pkg::SLEW_EXP_RESET;
         slew_mantissa <= 11'h000;
      end
      else if (load_state == vout_margin_pkg::ST_LOAD && nvm_ready)
         slew_mantissa <= nvm_slew_mantissa;
      else if (wr_slew && slew_ok)
      begin
         slew_exponent <= cmd_wdata[15:11];
         slew_mantissa <= cmd_wdata[10:0];
      end
   end

   // applied rate: stored value rounded to the nearest 1/16 mV/us hardware step
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         applied_rate_q4 <= 8'h01;
      else if (load_state == vout_margin_pkg::ST_LOAD && nvm_ready)
         applied_rate_q4 <= 8'((nvm_rate_q8 + vout_margin_pkg::SLEW_ROUND_Q8) >> 4);
      else if (wr_slew && slew_ok)
         applied_rate_q4 <= 8'((wr_rate_q8 + vout_margin_pkg::SLEW_ROUND_Q8) >> 4);
   end

   // target selection by the operation margin field, then limit clamp
   always_comb
   begin
      raw_target = margin_total(16'h0000) + {3'h0, nominal_target}
                   - (relative_mode ? {3'h0, nominal_target} : 19'h00000);
      case (margin_sel)
         vout_margin_pkg::MARGIN_HIGH:
            raw_target = margin_total(margin_high_value);
         vout_margin_pkg::MARGIN_LOW:
            raw_target = margin_total(margin_low_value);
         default:
            raw_target = {3'h0, nominal_target} + {{3{vout_trim[15]}}, vout_trim};
      endcase
      clamped = 1'b0;
      next_target = raw_target[15:0];
      if (!raw_target[18] && raw_target > {3'h0, vout_max})
      begin
         next_target = vout_max;
         clamped = 1'b1;
      end
      else if (raw_target[18] || raw_target < {3'h0, vout_min})
      begin
         next_target = vout_min;
         clamped = 1'b1;
      end
   end

   // a clamp raises the warning once per entry while converting
   assign warn_event = clamped && !clamped_d && conversion_on;

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         clamped_d <= 1'b0;
      else
         clamped_d <= clamped && conversion_on;
   end

   // the ramp sees the selected target and applied rate every cycle
   assign rp.target = next_target;
   assign rp.rate_q4 = applied_rate_q4;
   assign rp.step_mode = conversion_on;

   vout_ramp #(
      .TICK_CYCLES(TICK_CYCLES),
      .CODES_Q8(CODES_Q8)
   ) u_ramp (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .rp(rp)
   );

   // sticky status: an event in the clear cycle wins so nothing is lost
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         invalid_data_status <= 1'b0;
         max_min_warn_status <= 1'b0;
      end
      else
      begin
         if (invalid_event)
            invalid_data_status <= 1'b1;
         else if (status_clear)
            invalid_data_status <= 1'b0;
         if (warn_event)
            max_min_warn_status <= 1'b1;
         else if (status_clear)
            max_min_warn_status <= 1'b0;
      end
   end

   // alert stays asserted while either status bit is set
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         host_alert <= 1'b0;
      else
         host_alert <= invalid_event || warn_event
                       || ((invalid_data_status || max_min_warn_status) && !status_clear);
   end

   // one answer per request; reads return the stored words unchanged
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rsp_valid <= 1'b0;
         rsp_ack <= 1'b0;
         rsp_rdata <= 16'h0000;
      end
      else
      begin
         rsp_valid <= cmd_valid;
         rsp_ack <= cmd_valid && known_code && (load_state == vout_margin_pkg::ST_RUN);
         rsp_rdata <= 16'h0000;
         if (cmd_valid && !cmd_write && load_state == vout_margin_pkg::ST_RUN)
         begin
            case (cmd_code)
               vout_margin_pkg::CMD_MARGIN_HIGH:
                  rsp_rdata <= margin_high_value;
               vout_margin_pkg::CMD_MARGIN_LOW:
                  rsp_rdata <= margin_low_value;
               vout_margin_pkg::CMD_SLEW_RATE:
                  rsp_rdata <= {slew_exponent, slew_mantissa};
               default:
                  rsp_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // ramp results and load state to the pins, each from a flop
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         reference_code <= 16'h0000;
         ramp_busy <= 1'b0;
         loaded <= 1'b0;
      end
      else
      begin
         reference_code <= rp.reference;
         ramp_busy <= rp.busy;
         loaded <= (load_state == vout_margin_pkg::ST_RUN);
      end
   end
endmodule : vout_margin_slew_commands

// *** sim/vout_margin_checker.sv ***
// Purpose: port-level assertions for the margin and slew command block
// Assumes: one clock, asynchronous active-low reset
// Notes: the step bound allows for the fastest accepted slew plus one carry
`timescale 1ns/10ps
module vout_margin_checker #(
   parameter int TICK_CYCLES = 25,
   parameter int CODES_Q8 = 1049
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   input wire logic [15:0] rsp_rdata,
   input wire logic [15:0] vout_max,
   input wire logic [15:0] vout_min,
   input wire logic conversion_on,
   input wire logic status_clear,
   input wire logic [15:0] reference_code,
   input wire logic loaded,
   input wire logic invalid_data_status,
   input wire logic max_min_warn_status,
   input wire logic host_alert
);
   // largest move in one tick: q4 rate of 255 scaled to codes, plus a carry
   localparam int MAX_STEP = 255 * CODES_Q8 / 4096 + 1;
   logic [15:0] prev_ref;
   logic [15:0] ref_move;
   logic bad_slew;
   // reference of the previous edge, to measure each move
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         prev_ref <= 16'h0000;
      else
         prev_ref <= reference_code;
   end
   // only format faults are decoded here; range faults need the full scaling
   assign ref_move = (reference_code > prev_ref) ? reference_code - prev_ref
                                                 : prev_ref - reference_code;
   assign bad_slew = cmd_wdata[10] || ($signed(cmd_wdata[15:11]) > 5'sd4)
                     || ($signed(cmd_wdata[15:11]) < -5'sd8);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   a_rsp_follows: assert property (cmd_valid |=> rsp_valid)
      else $error("no response one cycle after a request");
   a_rsp_only_req: assert property (rsp_valid |-> $past(cmd_valid))
      else $error("response without a request");
   a_known_acked: assert property ((cmd_valid && loaded
      && cmd_code inside {8'h25, 8'h26, 8'h27}) |=> rsp_ack)
      else $error("known command not acknowledged");
   a_unknown_nack: assert property ((cmd_valid
      && !(cmd_code inside {8'h25, 8'h26, 8'h27})) |=> rsp_valid && !rsp_ack)
      else $error("unknown command acknowledged");
   a_write_no_data: assert property ((cmd_valid && cmd_write) |=> rsp_rdata == 16'h0000)
      else $error("read data driven on a write");
   a_bad_slew_flag: assert property ((cmd_valid && cmd_write && loaded
      && cmd_code == 8'h27 && bad_slew) |-> ##[1:2] (invalid_data_status && host_alert))
      else $error("bad slew word not flagged");
   a_status_sticky: assert property ((invalid_data_status && !status_clear)
      |=> invalid_data_status)
      else $error("invalid data flag dropped without clear");
   a_alert_level: assert property ((invalid_data_status || max_min_warn_status)
      |-> host_alert)
      else $error("status set without host alert");
   a_ramp_no_step: assert property ((conversion_on && loaded
      && $past(conversion_on, 4)) |-> ref_move <= MAX_STEP)
      else $error("reference stepped while converting");
   a_ref_in_limits: assert property ((loaded && !conversion_on && $stable(vout_max)
      && $stable(vout_min))[*4] |-> reference_code <= vout_max
      && reference_code >= vout_min)
      else $error("reference outside the limits");
endmodule : vout_margin_checker
bind vout_margin_slew_commands vout_margin_checker #(.TICK_CYCLES(TICK_CYCLES),
   .CODES_Q8(CODES_Q8)) chk (.ref_clk(ref_clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
   .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
   .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata), .vout_max(vout_max), .vout_min(vout_min),
   .conversion_on(conversion_on), .status_clear(status_clear),
   .reference_code(reference_code), .loaded(loaded),
   .invalid_data_status(invalid_data_status), .max_min_warn_status(max_min_warn_status),
   .host_alert(host_alert));

// *** sim/pmbus_host_model.sv ***
// Purpose: word read and write host on the decoded command port
// Assumes: requests launched at the falling edge, one taking edge each
// Notes: gap adds idle cycles to play a slow host
`timescale 1ns/10ps
module pmbus_host_model (
   input wire logic ref_clk,
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   input wire logic rsp_valid,
   input wire logic rsp_ack,
   input wire logic [15:0] rsp_rdata
);
   int gap = 0;
   // idle bus at time zero
   initial
   begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end
   // one word transfer; released lines show the inverse, never the old value
   task automatic xfer(input logic w, input logic [7:0] code, input logic [15:0] data,
                       output logic [1:0] rsp, output logic [15:0] rd);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_code = code;
      cmd_wdata = data;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      cmd_write = ~w;
      cmd_code = ~code;
      cmd_wdata = ~data;
      rsp = {rsp_valid, rsp_ack};
      rd = rsp_rdata;
      repeat (gap) @(negedge ref_clk);
   endtask : xfer
endmodule : pmbus_host_model

// *** sim/tb_vout_margin_slew_commands.sv ***
// Purpose: self-checking bench for the margin and slew command block
// Assumes: tick shortened to 2 cycles; inputs change at the falling edge
// Notes: the bench keeps its own copy of the three registers
`timescale 1ns/10ps
module tb_vout_margin_slew_commands;
   localparam int TICK = 2;
   logic ref_clk, reset_n = 1'b0, nvm_ready = 1'b0, relative_mode = 1'b0;
   logic conversion_on = 1'b0, status_clear = 1'b0, ld = 1'b0;
   logic cmd_valid, cmd_write, rsp_valid, rsp_ack;
   logic ramp_busy, loaded, invalid_data_status, max_min_warn_status, host_alert;
   logic [7:0] cmd_code;
   logic [1:0] margin_sel = 2'h0, rsp;
   logic [10:0] nvm_slew_mantissa = 11'h020;
   logic [15:0] cmd_wdata, rsp_rdata, reference_code, rd;
   logic [15:0] nvm_margin_high = 16'h1200, nvm_margin_low = 16'h0E00;
   logic [15:0] nominal_target = 16'h1000, vout_trim = 16'h0000;
   logic [15:0] vout_max = 16'h3000, vout_min = 16'h0400;
   logic [15:0] st[11] = '{16'hE001, 16'hE002, 16'hC012, 16'hC011, 16'hE0FE, 16'hE0FF,
                           16'hB864, 16'h2801, 16'h000F, 16'hE7FF, 16'h2000};
   int regs[3];
   int n_errors = 0, checked = 0, i;
   vout_margin_slew_commands #(.TICK_CYCLES(TICK)) uut (.ref_clk(ref_clk), .reset_n(reset_n),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack), .rsp_rdata(rsp_rdata),
      .nvm_ready(nvm_ready), .nvm_margin_high(nvm_margin_high),
      .nvm_margin_low(nvm_margin_low), .nvm_slew_mantissa(nvm_slew_mantissa),
      .margin_sel(margin_sel), .relative_mode(relative_mode), .nominal_target(nominal_target),
      .vout_trim(vout_trim), .vout_max(vout_max), .vout_min(vout_min),
      .conversion_on(conversion_on), .status_clear(status_clear),
      .reference_code(reference_code), .ramp_busy(ramp_busy), .loaded(loaded),
      .invalid_data_status(invalid_data_status), .max_min_warn_status(max_min_warn_status),
      .host_alert(host_alert));
   pmbus_host_model host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
      .rsp_rdata(rsp_rdata));
   // 25 MHz reference clock
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic report_and_stop();
      if (n_errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [15:0] seen, input logic [15:0] expv);
      checked++;
      if (seen !== expv)
      begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, expv);
      end
   endtask : check
   // decoded slew in q8 units, -1 where the word is not accepted
   function automatic int slew_q8(input logic [15:0] w);
      int e, m;
      e = $signed(w[15:11]);
      m = $signed(w[10:0]);
      if (m < 0 || e < -8 || e > 4)
         return -1;
      m = m << (e + 8);
      return (m < 18 || m > 4078) ? -1 : m;
   endfunction : slew_q8
   // selected target with trim, clamped to the present limits
   function automatic int tgt(input int sel);
      int v;
      v = (sel == 1) ? regs[1] : (sel == 2) ? regs[0] : int'(nominal_target);
      v += int'($signed(vout_trim));
      v += (relative_mode && (sel == 1 || sel == 2)) ? int'(nominal_target) : 0;
      return (v > int'(vout_max)) ? int'(vout_max) : (v < int'(vout_min)) ? int'(vout_min) : v;
   endfunction : tgt
   task automatic rd_chk(input logic [7:0] code);
      logic k;
      k = ld && code >= 8'h25 && code <= 8'h27;
      host.xfer(1'b0, code, 16'h0000, rsp, rd);
      check({14'h0, rsp}, {14'h0, 1'b1, k});
      if (k)
         check(rd, 16'(regs[code - 8'h25]));
   endtask : rd_chk
   // write with flags cleared first, then check the flag and read back
   task automatic wr(input logic [7:0] code, input logic [15:0] d);
      int bad, v;
      status_clear = 1'b1;
      @(negedge ref_clk);
      status_clear = 1'b0;
      v = int'(d) + int'($signed(vout_trim)) + (relative_mode ? int'(nominal_target) : 0);
      bad = (code == 8'h27) ? (slew_q8(d) < 0) : (v < 0 || v > int'(vout_max));
      host.xfer(1'b1, code, d, rsp, rd);
      check({14'h0, rsp}, 16'h0003);
      @(negedge ref_clk);
      check({14'h0, invalid_data_status, host_alert}, bad ? 16'h0003 : 16'h0000);
      if (!bad)
         regs[code - 8'h25] = d;
      rd_chk(code);
   endtask : wr
   // bounded wait for the reference to reach a value
   task automatic wait_ref(input logic [15:0] v, output int n);
      for (n = 0; n < 2000 && reference_code !== v; n++)
         @(negedge ref_clk);
      check(reference_code, v);
      if (n >= 2000)
         report_and_stop();
   endtask : wait_ref
   initial
   begin
      void'($urandom(32'h3b9902d6));
      nvm_margin_high = 16'h1000 + 16'($urandom_range(0, 16'h0FFF));
      repeat (16) @(negedge ref_clk);
      reset_n = 1'b1;
      rd_chk(8'h25);
      nvm_ready = 1'b1;
      for (i = 0; i < 50 && loaded !== 1'b1; i++)
         @(negedge ref_clk);
      if (loaded !== 1'b1)
      begin
         n_errors++;
         report_and_stop();
      end
      ld = 1'b1;
      regs = '{int'(nvm_margin_high), int'(nvm_margin_low), int'({5'h1C, nvm_slew_mantissa})};
      for (i = 0; i < 4; i++)
         rd_chk(8'(8'h24 + i));
      host.gap = 2;
      // random margins, some beyond the limit, then both boundaries
      for (i = 0; i < 8; i++)
         wr(8'(8'h25 + i % 2), 16'($urandom_range(0, 16'h3800)));
      wr(8'h25, 16'h3000);
      wr(8'h26, 16'h3001);
      relative_mode = 1'b1;
      wr(8'h25, 16'h2001);
      wr(8'h25, 16'h2000);
      host.gap = 0;
      foreach (st[j])
         wr(8'h27, st[j]);
      // every margin selection, absolute and relative, with and without low clamp
      for (i = 0; i < 16; i++)
      begin
         margin_sel = 2'(i);
         relative_mode = i[2];
         vout_trim = i[3] ? 16'hF000 : 16'($urandom_range(0, 16'h00FF));
         repeat (4) @(negedge ref_clk);
         check(reference_code, 16'(tgt(margin_sel)));
      end
      relative_mode = 1'b0;
      vout_trim = 16'h0000;
      margin_sel = 2'h0;
      wr(8'h27, 16'hE010);
      wr(8'h25, 16'h1320);
      repeat (4) @(negedge ref_clk);
      conversion_on = 1'b1;
      margin_sel = 2'h2;
      // 800 codes at 16 * 1049 / 4096 codes per tick takes about 392 cycles
      wait_ref(16'h1320, i);
      check(16'(i >= 360 && i <= 430), 16'h0001);
      check({15'h0, ramp_busy}, 16'h0000);
      vout_max = 16'h1200;
      repeat (4) @(negedge ref_clk);
      check({14'h0, max_min_warn_status, host_alert}, 16'h0003);
      check({15'h0, ramp_busy}, 16'h0001);
      wait_ref(16'h1200, i);
      conversion_on = 1'b0;
      margin_sel = 2'h1;
      repeat (4) @(negedge ref_clk);
      check(reference_code, 16'(tgt(1)));
      report_and_stop();
   end
endmodule : tb_vout_margin_slew_commands
